// ### core/tcif_flow.sv
// Maskable interrupt flagging, qualification and branch control.
`timescale 1ns/1ps
module tcif_flow (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [tcif_pkg::NUM_INT-1:0] int_req_in,
    input wire logic rt_halted_in,
    input wire logic [tcif_pkg::HALF_INT-1:0] int_enable_low_in,
    input wire logic [tcif_pkg::HIGH_INT-1:0] int_enable_high_in,
    input wire logic [tcif_pkg::HALF_INT-1:0] debug_int_enable_low_in,
    input wire logic [tcif_pkg::HIGH_INT-1:0] debug_int_enable_high_in,
    input wire logic [tcif_pkg::NUM_INT-1:0] flag_clear_in,
    input wire logic [tcif_pkg::CTX_W-1:0] status_in,
    input wire logic mode_write_in,
    input wire tcif_pkg::tcif_mode_t mode_wdata_in,
    input wire logic branch_done_in,
    input wire logic return_in,
    output logic [tcif_pkg::HALF_INT-1:0] pending_flags_low_out,
    output logic [tcif_pkg::HIGH_INT-1:0] pending_flags_high_out,
    output tcif_pkg::tcif_mode_t mode_out,
    output logic ack_out,
    output logic [tcif_pkg::VEC_W-1:0] vector_out,
    output logic flush_young_out,
    output logic branching_out,
    output logic restore_out,
    output logic [tcif_pkg::CTX_W-1:0] restore_status_out
);
    // Short alias for the number of interrupt lines.
    localparam int N = tcif_pkg::NUM_INT;

    // Registered state and its next values.
    logic [N-1:0] flags_reg, flags_next;
    logic [N-1:0] req_d_reg, req_d_next;
    tcif_pkg::tcif_mode_t mode_reg, mode_next;
    tcif_pkg::tcif_ctx_t ctx_reg, ctx_next;
    tcif_pkg::tcif_state_t state_reg, state_next;
    logic [tcif_pkg::VEC_W-1:0] vec_reg, vec_next;
    logic restore_reg, restore_next;
    logic [tcif_pkg::CTX_W-1:0] rstat_reg, rstat_next;
    logic [N-1:0] enable_all, debug_all, qualified, ack_mask;
    logic [N-1:0] req_rise;
    logic pick_any;
    logic [tcif_pkg::VEC_W-1:0] pick_idx;
    logic take;

    // Mode forced on entry to a service routine.
    function automatic tcif_pkg::tcif_mode_t fresh_mode();
        fresh_mode.global_int_disable = 1'b1;
        fresh_mode.debug_event_disable = 1'b1;
        fresh_mode.emulation_reg_access_permit = 1'b0;
    endfunction

    // Enables joined into one vector; the bit index is the vector number.
    assign enable_all = {int_enable_high_in, int_enable_low_in};
    assign debug_all = {debug_int_enable_high_in, debug_int_enable_low_in};
    // A request is valid on its rising edge, one flag setting per event.
    assign req_rise = int_req_in & ~req_d_reg;

    always_comb
    begin
        if (rt_halted_in)
        begin
            qualified = flags_reg & enable_all & debug_all;
        end
        else
        begin
            qualified = flags_reg & enable_all &
                {N{~mode_reg.global_int_disable}};
        end
    end

    // Lowest index wins among the qualified flags.
    tcif_prio #(
        .N(N),
        .W(tcif_pkg::VEC_W)
    ) u_prio (
        .req_in(qualified),
        .any_out(pick_any),
        .idx_out(pick_idx)
    );

    // Only an idle flow takes a new interrupt; a busy one leaves flags set.
    // unqualified requests ignored
    assign take = (state_reg == tcif_pkg::TCIF_IDLE) && pick_any;

    // Only the acknowledged bit is cleared by the branch.
    assign ack_mask = take ? (N'(1) << pick_idx) : '0;

    // Next values of flags, mode, context and the branch sequence.
    always_comb
    begin
        req_d_next = int_req_in;
        flags_next = (flags_reg & ~flag_clear_in & ~ack_mask) | req_rise;
        mode_next = mode_reg;
        ctx_next = ctx_reg;
        state_next = state_reg;
        vec_next = vec_reg;
        restore_next = 1'b0;
        rstat_next = rstat_reg;
        if (mode_write_in)
        begin
            mode_next = mode_wdata_in;
        end
        unique case (state_reg)
            tcif_pkg::TCIF_IDLE:
            begin
                if (take)
                begin
                    vec_next = pick_idx;
                    ctx_next.mode = mode_reg;
                    ctx_next.status = status_in;
                    // The forced mode beats a software write this cycle.
                    // fresh context
                    mode_next = fresh_mode();
                    state_next = tcif_pkg::TCIF_BRANCH;
                end
            end
            tcif_pkg::TCIF_BRANCH:
            begin
                if (branch_done_in)
                begin
                    state_next = tcif_pkg::TCIF_SERVICE;
                end
            end
            tcif_pkg::TCIF_SERVICE:
            begin
                if (return_in)
                begin
                    // The restored context beats a software write.
                    // context restore
                    mode_next = ctx_reg.mode;
                    rstat_next = ctx_reg.status;
                    restore_next = 1'b1;
                    state_next = tcif_pkg::TCIF_IDLE;
                end
            end
        endcase
    end


    // Registers only; every next value comes from the process above.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            flags_reg <= tcif_pkg::FLAGS_RST;
            req_d_reg <= tcif_pkg::FLAGS_RST;
            mode_reg.global_int_disable <= tcif_pkg::GIDIS_RST;
            mode_reg.debug_event_disable <= tcif_pkg::DBGDIS_RST;
            mode_reg.emulation_reg_access_permit <= tcif_pkg::EPERMIT_RST;
            ctx_reg.mode.global_int_disable <= tcif_pkg::GIDIS_RST;
            ctx_reg.mode.debug_event_disable <= tcif_pkg::DBGDIS_RST;
            ctx_reg.mode.emulation_reg_access_permit <= tcif_pkg::EPERMIT_RST;
            ctx_reg.status <= tcif_pkg::CTX_RST;
            state_reg <= tcif_pkg::TCIF_IDLE;
            vec_reg <= '0;
            restore_reg <= 1'b0;
            rstat_reg <= tcif_pkg::CTX_RST;
        end
        else
        begin
            flags_reg <= flags_next;
            req_d_reg <= req_d_next;
            mode_reg <= mode_next;
            ctx_reg <= ctx_next;
            state_reg <= state_next;
            vec_reg <= vec_next;
            restore_reg <= restore_next;
            rstat_reg <= rstat_next;
        end
    end


    // Outputs come from registers, except the ack and flush pulses.
    assign pending_flags_low_out = flags_reg[tcif_pkg::HALF_INT-1:0];
    assign pending_flags_high_out = flags_reg[N-1:tcif_pkg::HALF_INT];
    assign mode_out = mode_reg;
    assign ack_out = take;
    assign vector_out = vec_reg;
    assign flush_young_out = take;
    assign branching_out = (state_reg == tcif_pkg::TCIF_BRANCH);
    assign restore_out = restore_reg;
    assign restore_status_out = rstat_reg;
endmodule // tcif_flow

// ### core/tcif_pkg.sv
// Shared constants and types for the time-critical interrupt flow block.
package tcif_pkg;
    // Number of maskable interrupt lines, split into a low group of 16 and a high group of 8.
    localparam int NUM_INT = 24;
    localparam int HALF_INT = 16;
    localparam int HIGH_INT = NUM_INT - HALF_INT;
    localparam int VEC_W = 5;
    // Reset values of the pending, enable and context bits.
    localparam logic [NUM_INT-1:0] FLAGS_RST = 24'h000000;
    localparam logic [NUM_INT-1:0] ENABLE_RST = 24'h000000;
    localparam logic GIDIS_RST = 1'h1;
    localparam logic DBGDIS_RST = 1'h1;
    localparam logic EPERMIT_RST = 1'h0;
    // Width of the status word saved on a branch; the mode bits are kept apart.
    localparam int CTX_W = 16;
    localparam logic [CTX_W-1:0] CTX_RST = 16'h0000;

    // Mode bits that the interrupt flow forces and restores.
    typedef struct packed {
        logic global_int_disable;
        logic debug_event_disable;
        logic emulation_reg_access_permit;
    } tcif_mode_t;

    // Context saved automatically on a branch to the service routine.
    typedef struct packed {
        tcif_mode_t mode;
        logic [CTX_W-1:0] status;
    } tcif_ctx_t;

    typedef enum logic [1:0] {
        TCIF_IDLE,
        TCIF_BRANCH,
        TCIF_SERVICE
    } tcif_state_t;
endpackage

// ### core/tcif_prio.sv
// Lowest-index-first priority picker for qualified interrupt requests.
`timescale 1ns/1ps
module tcif_prio #(
    parameter int N = 24,
    parameter int W = 5
) (
    input wire logic [N-1:0] req_in,
    output logic any_out,
    output logic [W-1:0] idx_out
);
    always_comb
    begin
        any_out = 1'b0;
        idx_out = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req_in[i])
            begin
                any_out = 1'b1;
                idx_out = W'(i);
            end
        end
    end
endmodule // tcif_prio

// ### tb/tcif_flow_bench.sv
// Self-checking bench for the time-critical interrupt flow block.
`timescale 1ns/1ps
module tcif_flow_bench;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic go = 1'b0, halt = 1'b0, mw = 1'b0, bd = 1'b0, ret = 1'b0;
    logic [4:0] idx = 5'h00;
    logic [23:0] req, ien = 24'h100008, den = 24'h000000, clr = 24'h000000;
    wire [23:0] flg;
    logic [15:0] st = 16'hA5A5, rst_st;
    tcif_pkg::tcif_mode_t mwd = 3'h0, mode;
    logic hlt, ack, brn, rsto, fl;
    logic [4:0] vec;
    int fails = 0;
    int n_compared = 0;
    always #20 clk_in = ~clk_in;
    tcif_src tcif_src_inst (.clk_in(clk_in), .go_in(go), .idx_in(idx),
        .halt_in(halt), .int_req_out(req), .rt_halted_out(hlt));
    tcif_flow tcif_flow_inst (.clk_in(clk_in), .rst_in(rst_in),
        .int_req_in(req), .rt_halted_in(hlt),
        .int_enable_low_in(ien[15:0]), .int_enable_high_in(ien[23:16]),
        .debug_int_enable_low_in(den[15:0]),
        .debug_int_enable_high_in(den[23:16]), .flag_clear_in(clr),
        .status_in(st), .mode_write_in(mw), .mode_wdata_in(mwd),
        .branch_done_in(bd), .return_in(ret),
        .pending_flags_low_out(flg[15:0]),
        .pending_flags_high_out(flg[23:16]), .mode_out(mode),
        .ack_out(ack), .vector_out(vec), .flush_young_out(fl),
        .branching_out(brn), .restore_out(rsto),
        .restore_status_out(rst_st));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic fire(input logic [4:0] i);
        idx <= i;
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        tick(4);
        @(negedge clk_in);
    endtask
    task automatic setmode(input logic [2:0] m);
        tick(1);
        mw <= 1'b1;
        mwd <= m;
        tick(1);
        mw <= 1'b0;
    endtask
    task automatic svc(input logic [4:0] i, input logic [2:0] m0,
        input logic [15:0] s0);
        repeat (10)
        begin
            @(negedge clk_in);
            if (ack === 1'b1)
                break;
        end
        chk(ack, 1'h1);
        chk(fl, 1'h1);
        @(negedge clk_in);
        chk(vec, i);
        chk(flg[i], 1'h0);
        chk({brn, mode}, 4'hE);
        @(posedge clk_in);
        bd <= 1'b1;
        st <= ~st;
        tick(1);
        bd <= 1'b0;
        ret <= 1'b1;
        tick(1);
        ret <= 1'b0;
        @(negedge clk_in);
        chk({rsto, rst_st, 1'h0, mode}, {1'h1, s0, 1'h0, m0});
    endtask
    task automatic final_report;
        $display("Counts: %0d compared, %0d bad", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        tick(10);
        rst_in <= 1'b0;
        fire(5'h03);
        chk({brn, flg}, 25'h0000008);
        setmode(3'h0);
        svc(5'h03, 3'h0, 16'hA5A5);
        $display("Test standard flow done");
        @(posedge clk_in);
        halt <= 1'b1;
        setmode(3'h4);
        fire(5'h14);
        chk({brn, flg}, 25'h0100000);
        @(posedge clk_in);
        den <= 24'h100000;
        svc(5'h14, 3'h4, 16'h5A5A);
        $display("Test halted flow done");
        fire(5'h07);
        chk(flg, 24'h000080);
        @(posedge clk_in);
        clr <= 24'h000080;
        tick(1);
        clr <= 24'h000000;
        @(negedge clk_in);
        chk(flg, 24'h000000);
        $display("Test software clear done");
        final_report();
    end
    initial
    begin
        tick(400);
        fails++;
        final_report();
    end
endmodule // tcif_flow_bench

// ### tb/tcif_flow_props.sv
// Checker for the time-critical interrupt flow block.
`timescale 1ns/1ps
module tcif_flow_props (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [23:0] int_req_in,
    input wire logic rt_halted_in,
    input wire logic [15:0] int_enable_low_in,
    input wire logic [7:0] int_enable_high_in,
    input wire logic [15:0] debug_int_enable_low_in,
    input wire logic [7:0] debug_int_enable_high_in,
    input wire logic [15:0] status_in,
    input wire logic [15:0] pending_flags_low_out,
    input wire logic [7:0] pending_flags_high_out,
    input wire tcif_pkg::tcif_mode_t mode_out,
    input wire logic ack_out,
    input wire logic [4:0] vector_out,
    input wire logic flush_young_out,
    input wire logic branching_out,
    input wire logic restore_out,
    input wire logic [15:0] restore_status_out
);
    logic [23:0] f, e, d, r_reg, rise_reg, e_reg, d_reg;
    logic [15:0] s_reg;
    logic [2:0] m_reg;
    assign f = {pending_flags_high_out, pending_flags_low_out};
    assign e = {int_enable_high_in, int_enable_low_in};
    assign d = {debug_int_enable_high_in, debug_int_enable_low_in};
    // Keeps the inputs seen at the acknowledge for the later checks.
    always_ff @(posedge clk_in)
    begin
        r_reg <= int_req_in;
        rise_reg <= int_req_in & ~r_reg;
        e_reg <= e;
        d_reg <= d;
        s_reg <= ack_out ? status_in : s_reg;
        m_reg <= ack_out ? mode_out : m_reg;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    flag_set_a: assert property (&(f | ~rise_reg))
        else $error("request edge did not set its flag");
    ack_en_a: assert property (ack_out |=> e_reg[vector_out])
        else $error("ack without ordinary enable");
    ack_dbg_a: assert property (ack_out && rt_halted_in |=>
        d_reg[vector_out]) else $error("halted ack without debug enable");
    ack_gidis_a: assert property (ack_out && !rt_halted_in |->
        !mode_out.global_int_disable) else $error("ack while disabled");
    flush_ack_a: assert property (flush_young_out == ack_out)
        else $error("flush differs from ack");
    flag_clr_a: assert property (ack_out && $stable(int_req_in) |=>
        !f[vector_out]) else $error("acked flag not cleared");
    fresh_mode_a: assert property (ack_out |=>
        mode_out == 3'h6 && branching_out) else $error("bad forced mode");
    busy_noack_a: assert property (branching_out |-> !ack_out)
        else $error("ack during branch");
    restore_ctx_a: assert property (restore_out |->
        restore_status_out == s_reg && mode_out == m_reg)
        else $error("restored context differs");
    cover property (ack_out && rt_halted_in);
    cover property (ack_out && !rt_halted_in);
    cover property (restore_out);
endmodule // tcif_flow_props
bind tcif_flow tcif_flow_props tcif_flow_props_inst (.*);

// ### tb/tcif_src.sv
// Model of the peripheral request lines and the emulation halt control.
`timescale 1ns/1ps
module tcif_src (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [4:0] idx_in,
    input wire logic halt_in,
    output logic [23:0] int_req_out,
    output logic rt_halted_out
);
    // A request is one clock high, so each go makes exactly one edge.
    always_ff @(posedge clk_in)
    begin
        int_req_out <= go_in ? 24'h000001 << idx_in : 24'h000000;
        rt_halted_out <= halt_in;
    end
endmodule // tcif_src
